/* core/rws_defines.svh */
// offsets, field positions, reset values and timing counts of the random word source
`ifndef RWS_DEFINES_SVH
`define RWS_DEFINES_SVH

`define RWS_ADDR_W 8
`define RWS_OFF_CONFIG 8'h00
`define RWS_OFF_STATE 8'h04
`define RWS_OFF_WORD 8'h08

`define RWS_OFF_BIT_POS 2
`define RWS_READY_BIT_POS 0
`define RWS_WORD_W 16

`define RWS_CONFIG_RESET 32'h0000_0000
`define RWS_STATE_RESET 32'h0000_0000
`define RWS_WORD_RESET 16'h0000

`define RWS_SIZE_WORD 3'h2
`define RWS_RESP_OKAY 1'h0
`define RWS_RESP_ERROR 1'h1

`define RWS_PACE_NS 1250
`define RWS_CLK_NS 100
`define RWS_PACE_CYCLES ((`RWS_PACE_NS + `RWS_CLK_NS - 1) / `RWS_CLK_NS)

`endif

/* core/rws_noise_collector.sv */
// gathers noise bits into words, paced by the spacing timer
`timescale 1ns/1ps
module rws_noise_collector #(
  parameter int WORD_W = 16,
  parameter int PACE_CYCLES = 13
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // noise side
  input wire logic run,
  input wire logic noise_bit,
  // word side
  output logic word_valid,
  output logic [WORD_W-1:0] word
);
  localparam int BIT_W = $clog2(WORD_W + 1);

  logic [WORD_W-1:0] shift;
  logic [BIT_W-1:0] bits;
  logic pace_ok;
  logic emit;

  assign emit = run && pace_ok && (bits == BIT_W'(WORD_W));

  rws_pace_timer #(
    .PACE_CYCLES(PACE_CYCLES)
  ) u_pace (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(run),
    .restart(emit),
    .pace_ok(pace_ok)
  );

  // noise folded into the shift register every running cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift <= '0;
    end else if (run) begin
      shift <= {shift[WORD_W-2:0], noise_bit ^ shift[WORD_W-1]};
    end
  end

  // count of fresh bits since the last word
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bits <= '0;
    end else if (emit) begin
      bits <= '0;
    end else if (run && bits != BIT_W'(WORD_W)) begin
      bits <= bits + BIT_W'(1);
    end
  end

  // one-cycle word pulse with its data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word_valid <= 1'b0;
      word <= '0;
    end else begin
      word_valid <= emit;
      if (emit) begin
        word <= shift;
      end
    end
  end
endmodule // rws_noise_collector

/* core/rws_pace_timer.sv */
// spacing timer between successive random words
`timescale 1ns/1ps
module rws_pace_timer #(
  parameter int PACE_CYCLES = 13
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic restart,
  output logic pace_ok
);
  localparam int CNT_W = $clog2(PACE_CYCLES + 1);

  logic [CNT_W-1:0] count;

  // restart loads the interval, gated clock freezes the count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (run) begin
      if (restart) begin
        count <= CNT_W'(PACE_CYCLES - 1);
      end else if (count != '0) begin
        count <= count - CNT_W'(1);
      end
    end
  end

  assign pace_ok = (count == '0);
endmodule // rws_pace_timer

/* core/rws_pkg.sv */
// types shared by the random word source files
package rws_pkg;

  typedef logic [31:0] rws_data_type;

  typedef enum logic [1:0] {
    RWS_IDLE = 2'b00,
    RWS_READ_WAIT = 2'b01,
    RWS_ERR_FIRST = 2'b10,
    RWS_ERR_SECOND = 2'b11
  } rws_bus_state_type;

  typedef enum logic [1:0] {
    RWS_SEL_CONFIG = 2'b00,
    RWS_SEL_STATE = 2'b01,
    RWS_SEL_WORD = 2'b10,
    RWS_SEL_NONE = 2'b11
  } rws_sel_type;

  // write captured in the address phase, applied in the data phase
  typedef struct packed {
    logic valid;
    rws_sel_type sel;
  } rws_pend_type;

endpackage

/* core/rws_top.sv */
// random word source: bus slave, control and status around the noise collector
//
// Contract
// - word in bits 15:0, upper bits zero
// - off bit stops oscillators and generator clock
// - ready flag high only while word valid
// - word read while not ready stalls the bus
// - ready flag held low while generator off; a status read right behind the disabling write can still show it set
// - only word-sized accesses; others answer error
// - words spaced at least 1.25 us apart
// - configuration resets to zero, generator enabled
// - word readable anytime, from continuous noise; a word read while the generator is off stalls with no end
`timescale 1ns/1ps
`include "rws_defines.svh"
module rws_top #(
  parameter int PACE_CYCLES = `RWS_PACE_CYCLES,
  parameter int WORD_W = `RWS_WORD_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // system bus slave
  input wire logic hsel,
  input wire logic [`RWS_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire rws_pkg::rws_data_type hwdata,
  input wire logic hready,
  output rws_pkg::rws_data_type hrdata,
  output logic hreadyout,
  output logic hresp,
  // analog noise source
  input wire logic noise_bit,
  output logic gen_clk_enable,
  output logic osc_power_down
);
  import rws_pkg::*;

  // register select from an offset
  function automatic rws_sel_type rws_decode(input logic [`RWS_ADDR_W-1:0] a);
    case (a)
      `RWS_OFF_CONFIG: rws_decode = RWS_SEL_CONFIG;
      `RWS_OFF_STATE: rws_decode = RWS_SEL_STATE;
      `RWS_OFF_WORD: rws_decode = RWS_SEL_WORD;
      default: rws_decode = RWS_SEL_NONE;
    endcase
  endfunction

  rws_bus_state_type state;
  rws_pend_type pend;
  rws_data_type config_reg;
  rws_data_type config_now;
  rws_sel_type addr_sel;
  logic [WORD_W-1:0] word_reg;
  logic [WORD_W-1:0] coll_word;
  logic coll_valid;
  logic fresh;
  logic gen_off;
  logic addr_phase;
  logic accept;
  logic size_ok;
  logic take_word;

  // address phase qualification
  assign addr_phase = hsel && htrans[1] && hready;
  assign accept = addr_phase && (state == RWS_IDLE || state == RWS_ERR_SECOND);
  assign size_ok = (hsize == `RWS_SIZE_WORD);
  assign addr_sel = rws_decode(haddr);
  assign gen_off = config_reg[`RWS_OFF_BIT_POS];
  assign take_word = accept && size_ok && !hwrite && addr_sel == RWS_SEL_WORD && fresh;

  // configuration as seen by a read right behind a write
  assign config_now = (pend.valid && pend.sel == RWS_SEL_CONFIG) ? hwdata : config_reg;

  // noise collection runs only on the gated generator clock
  rws_noise_collector #(
    .WORD_W(WORD_W),
    .PACE_CYCLES(PACE_CYCLES)
  ) u_collect (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(gen_clk_enable),
    .noise_bit(noise_bit),
    .word_valid(coll_valid),
    .word(coll_word)
  );

  // write captured in the address phase, data taken next cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend <= '{valid: 1'b0, sel: RWS_SEL_NONE};
    end else begin
      pend.valid <= accept && size_ok && hwrite;
      pend.sel <= addr_sel;
    end
  end

  // configuration register, reserved bits stored as written
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      config_reg <= `RWS_CONFIG_RESET;
    end else if (pend.valid && pend.sel == RWS_SEL_CONFIG) begin
      config_reg <= hwdata;
    end
  end

  // generator clock gate and oscillator power-down
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gen_clk_enable <= 1'b0;
      osc_power_down <= 1'b1;
    end else begin
      gen_clk_enable <= !gen_off;
      osc_power_down <= gen_off;
    end
  end

  // latest word from the collector
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word_reg <= `RWS_WORD_RESET;
    end else if (coll_valid) begin
      word_reg <= coll_word;
    end
  end

  // ready flag: a new word wins over a read that clears it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fresh <= 1'b0;
    end else if (gen_off) begin
      fresh <= 1'b0;
    end else if (coll_valid && state != RWS_READ_WAIT) begin
      fresh <= 1'b1;
    end else if (take_word || (state == RWS_READ_WAIT && coll_valid)) begin
      fresh <= 1'b0;
    end
  end

  // bus answer: read data, wait states and two-cycle error
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= RWS_IDLE;
      hreadyout <= 1'b1;
      hresp <= `RWS_RESP_OKAY;
      hrdata <= '0;
    end else begin
      case (state)
        RWS_READ_WAIT: begin
          if (coll_valid) begin
            hrdata <= {{(32 - WORD_W){1'b0}}, coll_word};
            hreadyout <= 1'b1;
            state <= RWS_IDLE;
          end
        end
        RWS_ERR_FIRST: begin
          hreadyout <= 1'b1;
          state <= RWS_ERR_SECOND;
        end
        RWS_IDLE, RWS_ERR_SECOND: begin
          hresp <= `RWS_RESP_OKAY;
          hreadyout <= 1'b1;
          state <= RWS_IDLE;
          if (accept && !size_ok) begin
            hresp <= `RWS_RESP_ERROR;
            hreadyout <= 1'b0;
            state <= RWS_ERR_FIRST;
          end else if (accept && !hwrite) begin
            case (addr_sel)
              RWS_SEL_CONFIG: hrdata <= config_now;
              RWS_SEL_STATE: begin
                hrdata <= `RWS_STATE_RESET;
                // masked by the stored off bit, not config_now, so a read right behind the disabling write can still show a stale flag
                hrdata[`RWS_READY_BIT_POS] <= fresh && !gen_off;
              end
              RWS_SEL_WORD: begin
                if (fresh) begin
                  hrdata <= {{(32 - WORD_W){1'b0}}, word_reg};
                end else begin
                  hreadyout <= 1'b0;
                  state <= RWS_READ_WAIT;
                end
              end
              default: hrdata <= '0;
            endcase
          end
        end
        default: begin
          state <= RWS_IDLE;
          hreadyout <= 1'b1;
          hresp <= `RWS_RESP_OKAY;
        end
      endcase
    end
  end
endmodule // rws_top

/* verification/rws_checker.sv */
// port assertions for the random word source
`timescale 1ns/1ps
module rws_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire rws_pkg::rws_data_type hwdata,
  input wire logic hready,
  input wire rws_pkg::rws_data_type hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // generator control
  input wire logic gen_clk_enable,
  input wire logic osc_power_down
);
  import rws_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // accepted address phase and its size
  wire tk = hsel && htrans[1] && hready;
  wire ok = hsize == 3'h2;
  chk_upper_zero: assert property (hreadyout |-> hrdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  chk_err_two: assert property (tk && !ok |=>
    hresp && !hreadyout ##1 hresp && hreadyout)
    else $error("narrow access without two cycle error");
  chk_zero_wait: assert property (tk && ok && (hwrite || haddr != 8'h08) |=>
    hreadyout && !hresp)
    else $error("stall on a transfer that must not wait");
  chk_stall_bound: assert property ($fell(hreadyout) && !hresp && gen_clk_enable |->
    ##[1:24] hreadyout)
    else $error("stalled word read never ends");
  // data phase one edge after the address, register one later, pin one more
  chk_cfg_follow: assert property (tk && ok && hwrite && haddr == 8'h00 |->
    ##3 osc_power_down == $past(hwdata[2], 2))
    else $error("power down does not follow off bit");
  chk_reset_on: assert property ($fell(rst) |=> gen_clk_enable)
    else $error("generator not enabled after reset");
  chk_ready_off: assert property (tk && ok && !hwrite && haddr == 8'h04 && !gen_clk_enable |=>
    !hrdata[0])
    else $error("ready flag set while off");
  chk_clk_pair: assert property (gen_clk_enable != osc_power_down)
    else $error("clock gate and power down disagree");
  cover property (tk && !ok);
  cover property ($fell(hreadyout) && !hresp);
  cover property (tk && hwrite && haddr == 8'h00);
endmodule // rws_checker

bind rws_top rws_checker chk (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .gen_clk_enable, .osc_power_down);

/* verification/rws_noise_model.sv */
// noise oscillator model feeding the collector
`timescale 1ns/1ps
module rws_noise_model (
  // clock
  input wire logic clk_sys,
  // oscillator
  input wire logic osc_power_down,
  output logic noise_bit
);
  logic [7:0] sr = 8'h5b;
  // powered down it toggles, so a stale level never looks like noise
  always @(posedge clk_sys) begin
    sr <= osc_power_down ? ~sr : {sr[6:0], sr[7] ^ sr[5] ^ sr[4] ^ sr[3]};
  end
  assign noise_bit = sr[0];
endmodule // rws_noise_model

/* verification/rws_top_tb.sv */
// self-checking bench for the random word source
`timescale 1ns/1ps
module rws_top_tb;
  import rws_pkg::*;
  typedef struct {logic [7:0] a; logic w; logic [2:0] sz; rws_data_type d, r; logic e;} rws_row_type;
  logic clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp, e;
  logic noise_bit, gen_clk_enable, osc_power_down;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  rws_data_type hwdata, hrdata, r, r1;
  int err_count, n_tests, n;
  time t1;
  rws_row_type rows[10] = '{'{8'h00, 0, 3'h2, 0, 0, 0}, '{8'h0c, 0, 3'h2, 0, 0, 0},
    '{8'h04, 1, 3'h2, 1, 0, 0}, '{8'h00, 0, 3'h0, 0, 0, 1}, '{8'h00, 1, 3'h1, 4, 0, 1},
    '{8'h00, 0, 3'h2, 0, 0, 0}, '{8'h00, 1, 3'h2, 4, 0, 0}, '{8'h00, 0, 3'h2, 0, 4, 0},
    '{8'h04, 0, 3'h2, 0, 0, 0}, '{8'h00, 1, 3'h2, 0, 0, 0}};
  assign hready = hreadyout;
  rws_top dut (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .noise_bit, .gen_clk_enable, .osc_power_down);
  rws_noise_model nm (.clk_sys, .osc_power_down, .noise_bit);
  // one bus transfer, k counts wait cycles
  task automatic xfer(input logic [7:0] a, input logic w, input logic [2:0] sz,
    input rws_data_type d, output rws_data_type rd, output logic re, output int k);
    @(posedge clk_sys);
    #1 {hsel, htrans, haddr, hwrite, hsize} = {1'b1, 2'b10, a, w, sz};
    @(posedge clk_sys);
    #1 {hsel, htrans, hwdata} = {1'b0, 2'b00, d};
    k = 0;
    while (!hreadyout && k < 100) begin
      @(posedge clk_sys);
      #1 k++;
    end
    if (k == 100) err_count++;
    rd = hrdata;
    re = hresp;
  endtask
  task automatic chk(input string nm, input rws_data_type x, input rws_data_type g);
    n_tests++;
    if (g !== x) begin
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
      err_count++;
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // clock
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  // watchdog
  initial begin
    #300000;
    err_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    {rst, hsel, htrans, haddr, hwrite, hsize, hwdata} = {1'b1, 47'h0};
    repeat (2) @(posedge clk_sys);
    #1 rst = 0;
    foreach (rows[i]) begin
      xfer(rows[i].a, rows[i].w, rows[i].sz, rows[i].d, r, e, n);
      if (!rows[i].w) chk("rdata", rows[i].r, r);
      chk("resp", 32'(rows[i].e), 32'(e));
    end
    @(posedge clk_sys);
    #1 rst = 1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("rst_bus", 32'h2, 32'({hreadyout, hresp}));
    chk("rst_gen", 32'h1, 32'({gen_clk_enable, osc_power_down}));
    rst = 0;
    xfer(8'h08, 0, 3'h2, 0, r1, e, n);
    chk("stall", 1, 32'(n > 0));
    chk("upper", 0, 32'(r1[31:16]));
    xfer(8'h04, 0, 3'h2, 0, r, e, n);
    chk("flag_stalled", 0, r);
    repeat (18) @(posedge clk_sys);
    xfer(8'h04, 0, 3'h2, 0, r, e, n);
    chk("flag_set", 1, r);
    xfer(8'h08, 0, 3'h2, 0, r, e, n);
    chk("no_wait", 0, n);
    xfer(8'h04, 0, 3'h2, 0, r, e, n);
    chk("flag_clear", 0, r);
    xfer(8'h08, 0, 3'h2, 0, r1, e, n);
    t1 = $time;
    xfer(8'h08, 0, 3'h2, 0, r, e, n);
    chk("gap", 1, 32'($time - t1 >= 1250));
    chk("fresh", 1, 32'(r !== r1));
    // write then read of the configuration with no idle cycle between
    @(posedge clk_sys);
    #1 {hsel, htrans, haddr, hwrite, hsize} = {1'b1, 2'b10, 8'h00, 1'b1, 3'h2};
    @(posedge clk_sys);
    #1 {hwrite, hwdata} = {1'b0, 32'h4};
    @(posedge clk_sys);
    #1 {hsel, htrans} = 3'h0;
    chk("cfg_bypass", 32'h4, hrdata);
    xfer(8'h00, 1, 3'h2, 4, r, e, n);
    repeat (40) @(posedge clk_sys);
    xfer(8'h04, 0, 3'h2, 0, r, e, n);
    chk("flag_off", 0, r);
    chk("off_pins", 1, 32'({gen_clk_enable, osc_power_down}));
    end_of_test();
  end
endmodule // rws_top_tb
